// ---- inc/lco_pkg.sv ----
/*
 * lco_pkg: register map, field positions, reset values and source codes of the
 * lcd clock output controller.
 * assumes: a processor-side byte register port with bit-write support.
 */
package lco_pkg;
  localparam logic [15:0] CLOCK_OUTPUT_SELECT_ADDR = 16'hFF40;
  localparam logic [15:0] PORT_MODE_FOURTEEN_ADDR = 16'hFF2E;
  localparam logic [7:0] CLOCK_OUTPUT_SELECT_RESET = 8'h00;
  localparam logic [7:0] PORT_MODE_FOURTEEN_RESET = 8'hFF;
  localparam int OUTPUT_ENABLE_POS = 4;
  localparam int PIN_DIRECTION_POS = 0;
  localparam logic [7:0] CLOCK_OUTPUT_SELECT_MASK = 8'h1F;
  localparam logic [3:0] SRC_PRS_DIV64 = 4'h6;
  localparam logic [3:0] SRC_PRS_DIV128 = 4'h7;
  localparam logic [3:0] SRC_SUBSYSTEM = 4'h8;
  localparam int PRESCALE_WIDTH = 7;
  localparam int DIV64_BIT = 5;
  localparam int DIV128_BIT = 6;
endpackage : lco_pkg

// ---- verilog/lco_clock_output.sv ----
/*
 * lco_clock_output: clock source selection and glitch-free gating for the
 * clock delivered to the lcd controller/driver, with its two control registers.
 * assumes: i_clock is the peripheral clock; the subsystem clock arrives as a
 * slow level on i_sub_clock, synchronous to i_clock; byte or single-bit writes.
 */
`timescale 1ns/10ps
module lco_clock_output
  import lco_pkg::*;
(
  input wire logic i_clock,              // peripheral clock
  input wire logic i_reset_n,            // synchronous reset, active low
  input wire logic i_sub_clock,          // subsystem clock level
  input wire logic [15:0] i_addr,        // register address
  input wire logic i_wr,                 // write strobe
  input wire logic i_bit_op,             // single-bit write when high
  input wire logic [2:0] i_bit_sel,      // bit number for bit write
  input wire logic [7:0] i_wdata,        // write data (bit op uses bit 0)
  input wire logic i_rd,                 // read strobe
  output logic [7:0] o_rdata,            // read data
  output logic o_lcd_clock_out           // clock to lcd controller/driver
);

  typedef enum logic [1:0] {
    LCO_OFF = 2'b01,
    LCO_RUN = 2'b10
  } lco_state_e;

  logic [7:0] clock_output_select_reg;
  logic [7:0] port_mode_reg_fourteen;
  logic [PRESCALE_WIDTH-1:0] prescale_reg;
  logic sel_clock;
  logic sel_valid;
  logic want_on;
  logic gated_next;
  lco_state_e state_reg;
  logic [7:0] high_run_reg;

  function automatic logic [7:0] lco_write(input logic [7:0] cur, input logic [7:0] d,
                                           input logic bit_op, input logic [2:0] sel);
    logic [7:0] r;
    r = cur;
    if (bit_op) begin
      r[sel] = d[0];
    end else begin
      r = d;
    end
    return r;
  endfunction : lco_write

  // registers
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      clock_output_select_reg <= CLOCK_OUTPUT_SELECT_RESET;
    end else if (i_wr && i_addr == CLOCK_OUTPUT_SELECT_ADDR) begin
      // upper bits are not implemented and read zero
      clock_output_select_reg <= lco_write(clock_output_select_reg, i_wdata, i_bit_op,
                                           i_bit_sel) & CLOCK_OUTPUT_SELECT_MASK;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      port_mode_reg_fourteen <= PORT_MODE_FOURTEEN_RESET;
    end else if (i_wr && i_addr == PORT_MODE_FOURTEEN_ADDR) begin
      port_mode_reg_fourteen <= lco_write(port_mode_reg_fourteen, i_wdata, i_bit_op,
                                          i_bit_sel);
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd && i_addr == CLOCK_OUTPUT_SELECT_ADDR) begin
      o_rdata <= clock_output_select_reg;
    end else if (i_rd && i_addr == PORT_MODE_FOURTEEN_ADDR) begin
      o_rdata <= port_mode_reg_fourteen;
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // prescaler: free running divider of the peripheral clock
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      prescale_reg <= '0;
    end else begin
      prescale_reg <= prescale_reg + 1'b1;
    end
  end

  always_comb begin
    sel_valid = 1'b1;
    case (clock_output_select_reg[3:0])
      SRC_PRS_DIV64: sel_clock = prescale_reg[DIV64_BIT];
      SRC_PRS_DIV128: sel_clock = prescale_reg[DIV128_BIT];
      SRC_SUBSYSTEM: sel_clock = i_sub_clock;
      default: begin
        // prohibited codes give no clock
        sel_clock = 1'b0;
        sel_valid = 1'b0;
      end
    endcase
  end

  assign want_on = clock_output_select_reg[OUTPUT_ENABLE_POS]
                   && !port_mode_reg_fourteen[PIN_DIRECTION_POS] && sel_valid;

  // gate: opens only while source low, closes only once source is low again
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      state_reg <= LCO_OFF;
    end else begin
      case (state_reg)
        LCO_OFF: if (want_on && !sel_clock) state_reg <= LCO_RUN;
        LCO_RUN: if (!want_on && !sel_clock) state_reg <= LCO_OFF;
        default: state_reg <= LCO_OFF;
      endcase
    end
  end

  assign gated_next = (state_reg == LCO_RUN) ? sel_clock : 1'b0;

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_lcd_clock_out <= 1'b0;
    end else begin
      o_lcd_clock_out <= gated_next;
    end
  end

  // helper for the glitch check: cycles spent high in the current phase
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      high_run_reg <= 8'h00;
    end else if (!o_lcd_clock_out) begin
      high_run_reg <= 8'h00;
    end else if (high_run_reg != 8'hFF) begin
      high_run_reg <= high_run_reg + 8'h01;
    end
  end

  // register access
  chk_reset_values: assert property (@(posedge i_clock)
    !i_reset_n |=> clock_output_select_reg == CLOCK_OUTPUT_SELECT_RESET
      && port_mode_reg_fourteen == PORT_MODE_FOURTEEN_RESET && !o_lcd_clock_out)
    else $error("reset values wrong");
  chk_pm_reset: assert property (@(posedge i_clock)
    !i_reset_n |=> port_mode_reg_fourteen[PIN_DIRECTION_POS])
    else $error("direction bit not set");
  chk_bit_write: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_wr && i_bit_op && i_addr == PORT_MODE_FOURTEEN_ADDR
      |=> port_mode_reg_fourteen[$past(i_bit_sel)] == $past(i_wdata[0]))
    else $error("bit write lost");
  chk_cks_bit_write: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_wr && i_bit_op && i_addr == CLOCK_OUTPUT_SELECT_ADDR && i_bit_sel <= 3'h4
      |=> clock_output_select_reg[$past(i_bit_sel)] == $past(i_wdata[0]))
    else $error("select bit write lost");
  chk_byte_write: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_wr && !i_bit_op && i_addr == CLOCK_OUTPUT_SELECT_ADDR
      |=> clock_output_select_reg == ($past(i_wdata) & CLOCK_OUTPUT_SELECT_MASK))
    else $error("byte write lost");
  chk_read_select: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_rd && i_addr == CLOCK_OUTPUT_SELECT_ADDR |=> o_rdata == $past(clock_output_select_reg))
    else $error("select read wrong");
  chk_read_mode: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_rd && i_addr == PORT_MODE_FOURTEEN_ADDR |=> o_rdata == $past(port_mode_reg_fourteen))
    else $error("port mode read wrong");
  chk_read_idle: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    !i_rd |=> o_rdata == 8'h00) else $error("read data not cleared");

  // source selection and gate
  chk_disabled_low: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (!clock_output_select_reg[OUTPUT_ENABLE_POS] || port_mode_reg_fourteen[PIN_DIRECTION_POS])
      && state_reg == LCO_OFF |=> state_reg == LCO_OFF && !o_lcd_clock_out)
    else $error("output active while disabled");
  chk_bad_code_off: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    state_reg == LCO_OFF && clock_output_select_reg[3:0] != SRC_PRS_DIV64
      && clock_output_select_reg[3:0] != SRC_PRS_DIV128
      && clock_output_select_reg[3:0] != SRC_SUBSYSTEM |=> state_reg == LCO_OFF)
    else $error("prohibited source gave output");
  chk_div64_follow: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    state_reg == LCO_RUN && clock_output_select_reg[3:0] == SRC_PRS_DIV64
      |=> o_lcd_clock_out == $past(prescale_reg[DIV64_BIT]))
    else $error("div64 not followed");
  chk_div128_follow: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    state_reg == LCO_RUN && clock_output_select_reg[3:0] == SRC_PRS_DIV128
      |=> o_lcd_clock_out == $past(prescale_reg[DIV128_BIT]))
    else $error("div128 not followed");
  chk_sub_follow: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    state_reg == LCO_RUN && clock_output_select_reg[3:0] == SRC_SUBSYSTEM
      |=> o_lcd_clock_out == $past(i_sub_clock))
    else $error("subsystem clock not followed");
  chk_start_low: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    state_reg == LCO_OFF ##1 state_reg == LCO_RUN |-> !$past(sel_clock) && !o_lcd_clock_out)
    else $error("output started outside low phase");
  chk_stop_low: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    state_reg == LCO_RUN ##1 state_reg == LCO_OFF |-> !o_lcd_clock_out)
    else $error("output cut mid pulse");
  chk_high_full: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    o_lcd_clock_out && !gated_next
      && (clock_output_select_reg[3:0] == SRC_PRS_DIV64
      || clock_output_select_reg[3:0] == SRC_PRS_DIV128)
      |-> high_run_reg >= 8'((1 << DIV64_BIT) - 1))
    else $error("narrow high pulse");
  chk_idle_low: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    state_reg == LCO_OFF ##1 state_reg == LCO_OFF |-> !o_lcd_clock_out)
    else $error("output not low while stopped");
  cov_div64: cover property (@(posedge i_clock) state_reg == LCO_RUN
    && clock_output_select_reg[3:0] == 4'h6);
  cov_div128: cover property (@(posedge i_clock) state_reg == LCO_RUN
    && clock_output_select_reg[3:0] == 4'h7);
  cov_sub: cover property (@(posedge i_clock) state_reg == LCO_RUN
    && clock_output_select_reg[3:0] == 4'h8);
  cov_stop: cover property (@(posedge i_clock) state_reg == LCO_RUN ##1 state_reg == LCO_OFF);
  cov_open: cover property (@(posedge i_clock) state_reg == LCO_OFF ##1 state_reg == LCO_RUN);

endmodule : lco_clock_output

// ---- verification/lco_lcd_sink.sv ----
/* lco_lcd_sink: lcd side model, measures the phases of the delivered clock.
   assumes: the delivered clock is sampled on the rising peripheral clock. */
`timescale 1ns/10ps
module lco_lcd_sink (
  input wire logic i_clock,      // peripheral clock
  input wire logic i_reset_n,    // sync reset, active low
  input wire logic i_lcd_clock,  // delivered clock
  output logic [7:0] o_high_len, // last whole high phase
  output logic [7:0] o_low_len,  // last whole low phase
  output logic [7:0] o_rises     // rising edges seen
);
  logic prev_reg;
  logic [7:0] run_reg;
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      prev_reg <= 1'b0;
      run_reg <= 8'h00;
      o_high_len <= 8'h00;
      o_low_len <= 8'h00;
      o_rises <= 8'h00;
    end else begin
      prev_reg <= i_lcd_clock;
      run_reg <= (i_lcd_clock == prev_reg) ? run_reg + 8'h01 : 8'h01;
      if (i_lcd_clock && !prev_reg) begin
        o_low_len <= run_reg;
        o_rises <= o_rises + 8'h01;
      end
      if (!i_lcd_clock && prev_reg) begin
        o_high_len <= run_reg;
      end
    end
  end
endmodule : lco_lcd_sink

// ---- verification/testbench.sv ----
/* testbench: register accesses and clock phase checks of lco_clock_output.
   assumes: inputs change at the falling clock edge. */
`timescale 1ns/10ps
module testbench;
  import lco_pkg::*;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_sub_clock = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic i_wr = 1'b0;
  logic i_bit_op = 1'b0;
  logic [2:0] i_bit_sel = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata, hi, lo, rises, seen;
  logic o_lcd_clock_out;
  int failures = 0;
  int checks = 0;
  lco_clock_output u_lco_clock_output (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_sub_clock(i_sub_clock), .i_addr(i_addr), .i_wr(i_wr), .i_bit_op(i_bit_op),
    .i_bit_sel(i_bit_sel), .i_wdata(i_wdata), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_lcd_clock_out(o_lcd_clock_out));
  lco_lcd_sink u_lco_lcd_sink (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_lcd_clock(o_lcd_clock_out), .o_high_len(hi), .o_low_len(lo), .o_rises(rises));
  always #25 i_clock = ~i_clock;
  always begin
    repeat (40) @(negedge i_clock);
    i_sub_clock = ~i_sub_clock;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [15:0] a, input logic [7:0] d, input logic b, input logic [2:0] s);
    i_addr = a;
    i_wdata = d;
    i_bit_op = b;
    i_bit_sel = s;
    i_wr = 1'b1;
    @(negedge i_clock);
    i_wr = 1'b0;
    @(negedge i_clock);
  endtask : wr
  task rd(input logic [15:0] a, input logic [7:0] exp);
    i_addr = a;
    i_rd = 1'b1;
    @(negedge i_clock);
    i_rd = 1'b0;
    chk(o_rdata, exp);
    @(negedge i_clock);
  endtask : rd
  task report_and_stop;
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (2) @(negedge i_clock);
    i_reset_n = 1'b1;
    rd(CLOCK_OUTPUT_SELECT_ADDR, CLOCK_OUTPUT_SELECT_RESET);
    rd(PORT_MODE_FOURTEEN_ADDR, PORT_MODE_FOURTEEN_RESET);
    wr(CLOCK_OUTPUT_SELECT_ADDR, {4'h0, SRC_PRS_DIV64}, 1'b0, 3'h0);
    wr(CLOCK_OUTPUT_SELECT_ADDR, 8'h01, 1'b1, 3'h4);
    rd(CLOCK_OUTPUT_SELECT_ADDR, 8'h16);
    repeat (200) @(negedge i_clock);
    chk(rises, 8'h00);
    wr(PORT_MODE_FOURTEEN_ADDR, 8'h00, 1'b1, 3'h0);
    rd(PORT_MODE_FOURTEEN_ADDR, 8'hFE);
    repeat (200) @(negedge i_clock);
    chk(hi, 8'h20);
    chk(lo, 8'h20);
    wr(CLOCK_OUTPUT_SELECT_ADDR, {4'h0, SRC_PRS_DIV64}, 1'b0, 3'h0);
    repeat (100) @(negedge i_clock);
    chk(hi, 8'h20);
    chk({7'h00, o_lcd_clock_out}, 8'h00);
    for (int k = 0; k < 2; k++) begin
      wr(CLOCK_OUTPUT_SELECT_ADDR, {4'h0, k ? SRC_SUBSYSTEM : SRC_PRS_DIV128},
         1'b0, 3'h0);
      wr(CLOCK_OUTPUT_SELECT_ADDR, 8'h01, 1'b1, 3'h4);
      repeat (400) @(negedge i_clock);
      chk(hi, k ? 8'h28 : 8'h40);
      chk(lo, k ? 8'h28 : 8'h40);
      wr(CLOCK_OUTPUT_SELECT_ADDR, 8'h00, 1'b1, 3'h4);
      // let the gate finish its last high phase before the source changes
      repeat (140) @(negedge i_clock);
      chk({7'h00, o_lcd_clock_out}, 8'h00);
    end
    seen = rises;
    wr(CLOCK_OUTPUT_SELECT_ADDR, 8'h05, 1'b0, 3'h0);
    wr(CLOCK_OUTPUT_SELECT_ADDR, 8'h01, 1'b1, 3'h4);
    repeat (400) @(negedge i_clock);
    chk(rises, seen);
    i_reset_n = 1'b0;
    repeat (2) @(negedge i_clock);
    i_reset_n = 1'b1;
    rd(CLOCK_OUTPUT_SELECT_ADDR, CLOCK_OUTPUT_SELECT_RESET);
    rd(PORT_MODE_FOURTEEN_ADDR, PORT_MODE_FOURTEEN_RESET);
    report_and_stop();
  end
endmodule : testbench
